// ---- rtl/accr_channel_config.v ----
// channel 2 and channel 3 configuration register bank with channel 2 signal path controls
`timescale 1ns/1ns
`include "accr_regs.vh"
module accr_channel_config (
   input wire clk_i,
   input wire reset_i,
   input wire [7:0] page_i,
   input wire [6:0] addr_i,
   input wire wr_en_i,
   input wire [7:0] wr_data_i,
   input wire rd_en_i,
   output reg [7:0] rd_data_o,
   output reg rd_valid_o,
   input wire global_enhancer_select_i,
   input wire mod_en_i,
   input wire pdm_sample_i,
   input wire sample_valid_i,
   input wire signed [23:0] sample_i,
   input wire signed [17:0] volume_gain_i,
   input wire signed [17:0] trim_gain_i,
   output reg [1:0] chan2_input_impedance_o,
   output reg chan2_range_enhancer_o,
   output reg chan2_auto_gain_control_o,
   output reg [5:0] chan2_analog_gain_o,
   output reg [7:0] chan2_digital_volume_o,
   output reg [3:0] chan2_gain_trim_code_o,
   output reg [7:0] chan2_phase_delay_code_o,
   output reg chan3_input_kind_o,
   output reg [1:0] chan3_input_source_o,
   output reg chan3_coupling_select_o,
   output reg [1:0] chan3_input_impedance_o,
   output reg chan3_range_enhancer_o,
   output reg chan3_auto_gain_control_o,
   output reg pdm_delayed_o,
   output reg sample_valid_o,
   output reg signed [23:0] sample_o
);
   // ************************************************************
   // register storage
   // ************************************************************
   reg [7:0] chan2_input_setup_reg;
   reg [7:0] chan2_gain_setup_reg;
   reg [7:0] chan2_volume_setup_reg;
   reg [7:0] chan2_gain_trim_reg;
   reg [7:0] chan2_phase_trim_reg;
   reg [7:0] chan3_input_setup_reg;
   reg sel_meta_reg;
   reg sel_sync_reg;
   wire page_hit;
   wire pdm_delayed;
   reg [7:0] rd_next;
   reg [7:0] input_wr_next;
   wire wr_hit;
   wire [1:0] enh_bit;
   wire [1:0] enh_on;
   wire [1:0] agc_on;

   assign page_hit = (page_i == `ACCR_PAGE);
   assign wr_hit = wr_en_i & page_hit;

   // reserved bit 1 dropped; reserved codes are stored as written
   always @* begin
      input_wr_next = wr_data_i & `ACCR_MASK_INPUT;
   end

   // global mode select crosses in from another block's pin
   always @(posedge clk_i) begin
      if (reset_i) begin
         sel_meta_reg <= 1'b0;
         sel_sync_reg <= 1'b0;
      end else begin
         sel_meta_reg <= global_enhancer_select_i;
         sel_sync_reg <= sel_meta_reg;
      end
   end

   // ************************************************************
   // enhancer mode decode, one lane per channel
   // ************************************************************
   genvar ch;
   assign enh_bit =
      {chan3_input_setup_reg[`ACCR_POS_ENH], chan2_input_setup_reg[`ACCR_POS_ENH]};
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_mode
         // bit clear disables both; set picks one by the global select
         assign enh_on[ch] = enh_bit[ch] & ~sel_sync_reg;
         assign agc_on[ch] = enh_bit[ch] & sel_sync_reg;
      end
   endgenerate

   // ************************************************************
   // writes
   // ************************************************************
   always @(posedge clk_i) begin
      if (reset_i) begin
         chan2_input_setup_reg <= `ACCR_RST_INPUT;
      end else if (wr_hit && addr_i == `ACCR_OFS_CH2_INPUT) begin
         chan2_input_setup_reg <= input_wr_next;
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan2_gain_setup_reg <= `ACCR_RST_GAIN;
      end else if (wr_hit && addr_i == `ACCR_OFS_CHAN2_ANALOG_GAIN) begin
         chan2_gain_setup_reg <= wr_data_i & `ACCR_MASK_GAIN;
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan2_volume_setup_reg <= `ACCR_RST_VOLUME;
      end else if (wr_hit && addr_i == `ACCR_OFS_CH2_VOLUME) begin
         chan2_volume_setup_reg <= wr_data_i;
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan2_gain_trim_reg <= `ACCR_RST_TRIM;
      end else if (wr_hit && addr_i == `ACCR_OFS_CH2_TRIM) begin
         chan2_gain_trim_reg <= wr_data_i & `ACCR_MASK_TRIM;
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan2_phase_trim_reg <= `ACCR_RST_PHASE;
      end else if (wr_hit && addr_i == `ACCR_OFS_CH2_PHASE) begin
         chan2_phase_trim_reg <= wr_data_i;
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan3_input_setup_reg <= `ACCR_RST_INPUT;
      end else if (wr_hit && addr_i == `ACCR_OFS_CH3_INPUT) begin
         chan3_input_setup_reg <= input_wr_next;
      end
   end

   // ************************************************************
   // reads, one cycle after the strobe
   // ************************************************************
   always @* begin
      case (addr_i)
         `ACCR_OFS_CH2_INPUT: rd_next = chan2_input_setup_reg;
         `ACCR_OFS_CHAN2_ANALOG_GAIN: rd_next = chan2_gain_setup_reg;
         `ACCR_OFS_CH2_VOLUME: rd_next = chan2_volume_setup_reg;
         `ACCR_OFS_CH2_TRIM: rd_next = chan2_gain_trim_reg;
         `ACCR_OFS_CH2_PHASE: rd_next = chan2_phase_trim_reg;
         `ACCR_OFS_CH3_INPUT: rd_next = chan3_input_setup_reg;
         default: rd_next = 8'h00;
      endcase
      if (!page_hit) begin
         rd_next = 8'h00;
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= rd_en_i;
      end
   end

   // data holds between reads so a slow host can pick it up later
   always @(posedge clk_i) begin
      if (reset_i) begin
         rd_data_o <= 8'h00;
      end else if (rd_en_i) begin
         rd_data_o <= rd_next;
      end
   end

   // ************************************************************
   // field outputs to the analog and digital path
   // ************************************************************
   always @(posedge clk_i) begin
      if (reset_i) begin
         chan2_input_impedance_o <= 2'h0;
      end else begin
         chan2_input_impedance_o <=
            chan2_input_setup_reg[`ACCR_POS_IMP_HI:`ACCR_POS_IMP_LO];
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan2_range_enhancer_o <= 1'b0;
      end else begin
         chan2_range_enhancer_o <= enh_on[0];
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan2_auto_gain_control_o <= 1'b0;
      end else begin
         chan2_auto_gain_control_o <= agc_on[0];
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan2_analog_gain_o <= 6'h00;
      end else begin
         chan2_analog_gain_o <=
            chan2_gain_setup_reg[`ACCR_POS_GAIN_HI:`ACCR_POS_GAIN_LO];
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan2_digital_volume_o <= `ACCR_RST_VOLUME;
      end else begin
         chan2_digital_volume_o <= chan2_volume_setup_reg;
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan2_gain_trim_code_o <= `ACCR_RST_TRIM_CODE;
      end else begin
         chan2_gain_trim_code_o <=
            chan2_gain_trim_reg[`ACCR_POS_TRIM_HI:`ACCR_POS_TRIM_LO];
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan2_phase_delay_code_o <= 8'h00;
      end else begin
         chan2_phase_delay_code_o <= chan2_phase_trim_reg;
      end
   end

   // ************************************************************
   // channel 3 input setup fields
   // ************************************************************
   always @(posedge clk_i) begin
      if (reset_i) begin
         chan3_input_kind_o <= 1'b0;
      end else begin
         chan3_input_kind_o <= chan3_input_setup_reg[`ACCR_POS_KIND];
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan3_input_source_o <= 2'h0;
      end else begin
         chan3_input_source_o <=
            chan3_input_setup_reg[`ACCR_POS_SRC_HI:`ACCR_POS_SRC_LO];
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan3_coupling_select_o <= 1'b0;
      end else begin
         chan3_coupling_select_o <= chan3_input_setup_reg[`ACCR_POS_COUPLE];
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan3_input_impedance_o <= 2'h0;
      end else begin
         chan3_input_impedance_o <=
            chan3_input_setup_reg[`ACCR_POS_IMP_HI:`ACCR_POS_IMP_LO];
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan3_range_enhancer_o <= 1'b0;
      end else begin
         chan3_range_enhancer_o <= enh_on[1];
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         chan3_auto_gain_control_o <= 1'b0;
      end else begin
         chan3_auto_gain_control_o <= agc_on[1];
      end
   end

   // ************************************************************
   // phase delay in modulator clock steps
   // ************************************************************
   accr_phase_delay u_phase_delay (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .mod_en_i(mod_en_i),
      .delay_i(chan2_phase_trim_reg),
      .sample_i(pdm_sample_i),
      .sample_o(pdm_delayed)
   );

   always @(posedge clk_i) begin
      if (reset_i) begin
         pdm_delayed_o <= 1'b0;
      end else begin
         pdm_delayed_o <= pdm_delayed;
      end
   end

   // ************************************************************
   // volume and trim multipliers, two-stage pipeline
   // ************************************************************
   // gains are Q2.16 linear factors from the lookup outside; the dB to linear
   // table is kept outside so it can be shared across channels
   reg signed [41:0] stage1_prod;
   reg signed [23:0] stage1_reg;
   reg stage1_valid_reg;
   reg stage1_mute_reg;
   reg signed [41:0] stage2_prod;

   always @* begin
      stage1_prod = sample_i * trim_gain_i;
      stage2_prod = stage1_reg * volume_gain_i;
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         stage1_reg <= 24'h000000;
         stage1_valid_reg <= 1'b0;
         stage1_mute_reg <= 1'b0;
         sample_valid_o <= 1'b0;
         sample_o <= 24'h000000;
      end else begin
         stage1_valid_reg <= sample_valid_i;
         sample_valid_o <= stage1_valid_reg;
         if (sample_valid_i) begin
            stage1_reg <= stage1_prod[39:16];
            stage1_mute_reg <= (chan2_volume_setup_reg == `ACCR_VOL_MUTE);
         end
         if (stage1_valid_reg) begin
            if (stage1_mute_reg) begin
               sample_o <= 24'h000000;
            end else begin
               sample_o <= stage2_prod[39:16];
            end
         end
      end
   end
endmodule // accr_channel_config

// ---- rtl/accr_phase_delay.v ----
// variable delay line in modulator clock steps for one channel
`timescale 1ns/1ns
module accr_phase_delay (
   input wire clk_i,
   input wire reset_i,
   input wire mod_en_i,
   input wire [7:0] delay_i,
   input wire sample_i,
   output reg sample_o
);
   // ************************************************************
   // shift line, tap N gives N modulator clocks of delay
   // ************************************************************
   reg [255:1] line_reg;
   wire [255:0] tap;
   genvar g;

   // tap 0 is the live input, so the stored line has one driver per bit
   assign tap = {line_reg, sample_i};

   generate
      for (g = 1; g < 256; g = g + 1) begin : g_tap
         always @(posedge clk_i) begin
            if (reset_i) begin
               line_reg[g] <= 1'b0;
            end else if (mod_en_i) begin
               line_reg[g] <= tap[g-1];
            end
         end
      end
   endgenerate

   // code zero takes the undelayed sample
   always @(posedge clk_i) begin
      if (reset_i) begin
         sample_o <= 1'b0;
      end else begin
         sample_o <= tap[delay_i];
      end
   end
endmodule // accr_phase_delay

// ---- rtl/accr_regs.vh ----
// register offsets, field positions, reset values, write masks and field codes for the channel config bank
`ifndef ACCR_REGS_VH
`define ACCR_REGS_VH

`define ACCR_PAGE 8'h00
`define ACCR_OFS_CH2_INPUT 7'h41
`define ACCR_OFS_CHAN2_ANALOG_GAIN 7'h42
`define ACCR_OFS_CH2_VOLUME 7'h43
`define ACCR_OFS_CH2_TRIM 7'h44
`define ACCR_OFS_CH2_PHASE 7'h45
`define ACCR_OFS_CH3_INPUT 7'h46

`define ACCR_RST_INPUT 8'h00
`define ACCR_RST_GAIN 8'h00
`define ACCR_RST_VOLUME 8'hC9
`define ACCR_RST_TRIM 8'h80
`define ACCR_RST_PHASE 8'h00
`define ACCR_RST_TRIM_CODE 4'h8

`define ACCR_MASK_INPUT 8'hFD
`define ACCR_MASK_GAIN 8'hFC
`define ACCR_MASK_TRIM 8'hF0

`define ACCR_POS_KIND 7
`define ACCR_POS_SRC_HI 6
`define ACCR_POS_SRC_LO 5
`define ACCR_POS_COUPLE 4
`define ACCR_POS_IMP_HI 3
`define ACCR_POS_IMP_LO 2
`define ACCR_POS_ENH 0
`define ACCR_POS_GAIN_HI 7
`define ACCR_POS_GAIN_LO 2
`define ACCR_POS_TRIM_HI 7
`define ACCR_POS_TRIM_LO 4
`define ACCR_POS_GLOBAL_SEL 3

`define ACCR_GAIN_MAX 6'h2A
`define ACCR_IMP_RESERVED 2'h3
`define ACCR_SRC_RESERVED 2'h3
`define ACCR_VOL_MUTE 8'h00
`define ACCR_PHASE_DEPTH 256

`endif

// ---- verification/accr_cfg_monitor.sv ----
// concurrent checks on the ports of the channel configuration bank
`timescale 1ns/1ns
module accr_cfg_monitor (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [7:0] page_i,
   input wire logic [6:0] addr_i,
   input wire logic wr_en_i,
   input wire logic [7:0] wr_data_i,
   input wire logic rd_en_i,
   input wire logic [7:0] rd_data_o,
   input wire logic rd_valid_o,
   input wire logic sample_valid_i,
   input wire logic sample_valid_o,
   input wire logic signed [23:0] sample_o,
   input wire logic [7:0] chan2_digital_volume_o,
   input wire logic [5:0] chan2_analog_gain_o,
   input wire logic chan2_range_enhancer_o,
   input wire logic chan2_auto_gain_control_o
);
   default clocking mon_cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   wire wr0 = wr_en_i && page_i == 8'h00;
   // ***********
   // assertions
   // ***********
   a_vol_write_field: assert property (
      wr0 && addr_i == 7'h43 |-> ##2 chan2_digital_volume_o == $past(wr_data_i, 2))
      else $error("volume field differs from write");
   a_gain_write_field: assert property (
      wr0 && addr_i == 7'h42 |-> ##2 chan2_analog_gain_o == $past(wr_data_i[7:2], 2))
      else $error("gain field differs from write");
   a_foreign_read_zero: assert property (
      rd_en_i && page_i != 8'h00 |=> rd_valid_o && rd_data_o == 8'h00)
      else $error("foreign page read not zero");
   a_read_single_pulse: assert property (
      rd_en_i ##1 !rd_en_i |-> rd_valid_o ##1 !rd_valid_o)
      else $error("read valid not a single pulse");
   a_trim_reserved_zero: assert property (
      rd_en_i && page_i == 8'h00 && addr_i == 7'h44 |=> rd_data_o[3:0] == 4'h0)
      else $error("reserved trim bits not zero");
   a_mode_one_hot: assert property (
      !(chan2_range_enhancer_o && chan2_auto_gain_control_o))
      else $error("enhancer and agc both on");
   a_mute_output: assert property (
      sample_valid_i ##1 chan2_digital_volume_o == 8'h00 |-> ##1 sample_o == 24'sh0)
      else $error("muted sample not zero");
   a_sample_latency: assert property (
      sample_valid_i |-> ##2 sample_valid_o)
      else $error("sample valid latency wrong");
   c_volume_write: cover property (wr0 && addr_i == 7'h43);
   c_sample_out: cover property (sample_valid_o);
   c_foreign_read: cover property (rd_en_i && page_i != 8'h00);
endmodule // accr_cfg_monitor

bind accr_channel_config accr_cfg_monitor mon_u (.clk_i, .reset_i, .page_i, .addr_i,
   .wr_en_i, .wr_data_i, .rd_en_i, .rd_data_o, .rd_valid_o, .sample_valid_i,
   .sample_valid_o, .sample_o, .chan2_digital_volume_o, .chan2_analog_gain_o,
   .chan2_range_enhancer_o, .chan2_auto_gain_control_o);

// ---- verification/adc_channel_config_regs_tb_top.sv ----
// self-checking bench for the channel configuration bank
`timescale 1ns/1ns
module adc_channel_config_regs_tb_top;
   logic clk_i, reset_i, wr_en_i, rd_en_i, rd_valid_o, global_enhancer_select_i, mod_en_i;
   logic pdm_sample_i, sample_valid_i, sample_valid_o, pdm_delayed_o, chan3_input_kind_o;
   logic chan2_range_enhancer_o, chan2_auto_gain_control_o, chan3_coupling_select_o;
   logic chan3_range_enhancer_o, chan3_auto_gain_control_o;
   logic [7:0] page_i, wr_data_i, rd_data_o, chan2_digital_volume_o, chan2_phase_delay_code_o;
   logic [6:0] addr_i;
   logic [1:0] chan2_input_impedance_o, chan3_input_source_o, chan3_input_impedance_o;
   logic [5:0] chan2_analog_gain_o;
   logic [3:0] chan2_gain_trim_code_o;
   logic signed [23:0] sample_i, sample_o;
   logic signed [17:0] volume_gain_i, trim_gain_i;
   int err_total, comparisons;
   logic [6:0] ofs [6] = '{7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46};
   logic [7:0] rst [6] = '{8'h00, 8'h00, 8'hC9, 8'h80, 8'h00, 8'h00};
   // gain written as 42 with reserved bits set, never a code above 42
   logic [7:0] wdat [6] = '{8'h9B, 8'hAB, 8'hFF, 8'hFF, 8'hFF, 8'hD7};
   logic [7:0] rdbk [6] = '{8'h99, 8'hA8, 8'hFF, 8'hF0, 8'hFF, 8'hD5};
   accr_channel_config dut_u (.clk_i, .reset_i, .page_i, .addr_i, .wr_en_i, .wr_data_i,
      .rd_en_i, .rd_data_o, .rd_valid_o, .global_enhancer_select_i, .mod_en_i, .pdm_sample_i,
      .sample_valid_i, .sample_i, .volume_gain_i, .trim_gain_i, .chan2_input_impedance_o,
      .chan2_range_enhancer_o, .chan2_auto_gain_control_o, .chan2_analog_gain_o,
      .chan2_digital_volume_o, .chan2_gain_trim_code_o, .chan2_phase_delay_code_o,
      .chan3_input_kind_o, .chan3_input_source_o, .chan3_coupling_select_o,
      .chan3_input_impedance_o, .chan3_range_enhancer_o, .chan3_auto_gain_control_o,
      .pdm_delayed_o, .sample_valid_o, .sample_o);
   // *******
   // helpers
   // *******
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      addr_i = a;
      wr_data_i = d;
      wr_en_i = 1'b1;
      tick(1);
      wr_en_i = 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      addr_i = a;
      rd_en_i = 1'b1;
      tick(1);
      rd_en_i = 1'b0;
      chk(rd_valid_o, 1'b1);
      chk(rd_data_o, e);
      tick(1);
   endtask
   task automatic samp(input logic [23:0] s, input logic [23:0] e);
      sample_i = s;
      sample_valid_i = 1'b1;
      tick(1);
      sample_valid_i = 1'b0;
      tick(1);
      chk(sample_valid_o, 1'b1);
      chk(sample_o, e);
   endtask
   task automatic results;
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // *********
   // scenarios
   // *********
   task automatic t_reset_values;
      for (int i = 0; i < 6; i++) rd(ofs[i], rst[i]);
      chk(chan2_digital_volume_o, 8'hC9);
      chk(chan2_gain_trim_code_o, 4'h8);
   endtask
   task automatic t_write_fields;
      for (int i = 0; i < 6; i++) begin
         wr(ofs[i], wdat[i]);
         rd(ofs[i], rdbk[i]);
      end
      tick(2);
      chk(chan2_input_impedance_o, 2'h2);
      chk(chan2_analog_gain_o, 6'h2A);
      chk(chan2_digital_volume_o, 8'hFF);
      chk(chan2_gain_trim_code_o, 4'hF);
      chk(chan2_phase_delay_code_o, 8'hFF);
      chk({chan3_input_kind_o, chan3_input_source_o, chan3_coupling_select_o}, 4'hD);
      chk(chan3_input_impedance_o, 2'h1);
      chk({chan2_range_enhancer_o, chan2_auto_gain_control_o}, 2'h2);
      global_enhancer_select_i = 1'b1;
      tick(4);
      chk({chan2_range_enhancer_o, chan2_auto_gain_control_o}, 2'h1);
      chk({chan3_range_enhancer_o, chan3_auto_gain_control_o}, 2'h1);
      wr(7'h41, 8'h00);
      tick(2);
      chk({chan2_range_enhancer_o, chan2_auto_gain_control_o}, 2'h0);
   endtask
   task automatic t_foreign;
      page_i = 8'h01;
      wr(7'h43, 8'h11);
      rd(7'h43, 8'h00);
      page_i = 8'h00;
      rd(7'h43, 8'hFF);
      rd(7'h47, 8'h00);
   endtask
   task automatic t_mid_reset;
      reset_i = 1'b1;
      tick(2);
      reset_i = 1'b0;
      t_reset_values;
   endtask
   task automatic t_samples;
      volume_gain_i = 18'sh10000;
      trim_gain_i = 18'sh08000;
      samp(24'h123456, 24'h091A2B);
      volume_gain_i = 18'sh08000;
      samp(24'h123456, 24'h048D15);
      wr(7'h43, 8'h00);
      samp(24'h123456, 24'h000000);
   endtask
   task automatic t_phase(input logic [7:0] n);
      int c;
      wr(7'h45, n);
      mod_en_i = 1'b1;
      tick(n + 4);
      pdm_sample_i = 1'b1;
      c = 0;
      while (pdm_delayed_o !== 1'b1 && c < 300) begin
         tick(1);
         c++;
      end
      chk(c, n + 2);
      pdm_sample_i = 1'b0;
      mod_en_i = 1'b0;
   endtask
   // ****
   // main
   // ****
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      // a full pass takes under 1500 cycles
      #400000;
      err_total++;
      results;
   end
   initial begin
      reset_i = 1'b1;
      {wr_en_i, rd_en_i, mod_en_i, pdm_sample_i, sample_valid_i} = '0;
      {global_enhancer_select_i, page_i, addr_i, wr_data_i} = '0;
      {sample_i, volume_gain_i, trim_gain_i} = '0;
      tick(8);
      reset_i = 1'b0;
      t_reset_values;
      t_write_fields;
      t_foreign;
      t_mid_reset;
      t_samples;
      t_phase(8'h00);
      t_phase(8'h03);
      t_phase(8'hFF);
      results;
   end
endmodule // adc_channel_config_regs_tb_top
